// file: standby_pkg.sv
// Shared constants and carrier types for the standby, reset and low-voltage controller
package standby_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_SLEEP = 8'h00;
    localparam logic [7:0] OFS_CLOCK = 8'h04;
    localparam logic [7:0] OFS_KEYSEL0 = 8'h08;
    localparam logic [7:0] OFS_KEYSEL1 = 8'h0C;
    localparam logic [7:0] OFS_WAKELVL = 8'h10;
    localparam logic [7:0] OFS_LOWVOLT_CTRL_REG = 8'h14;
    localparam logic [7:0] OFS_BATT = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;

    // Field positions in clock_ctrl_reg
    localparam int CK_PCLK_EN = 0;
    localparam int CK_TAP10_SEL = 1;
    localparam int CK_TAP_GATE = 2;
    localparam int CK_STS_LO = 3;
    localparam int CK_STS_HI = 5;

    // Other field positions
    localparam int SLP_ENTER = 0;
    localparam int LVD_EN = 0;
    localparam int STAT_SRC_HI = 4;
    localparam int STAT_LOWV = 5;

    // Reset values
    localparam logic PCLK_EN_RST = 1'b1;
    localparam logic TAP10_SEL_RST = 1'b1;
    localparam logic TAP_GATE_RST = 1'b0;
    localparam logic [2:0] STS_RST = 3'h7;
    localparam logic [7:0] KEYSEL_RST = 8'h00;
    localparam logic [15:0] WAKELVL_RST = 16'h0000;
    localparam logic LVD_EN_RST = 1'b1;

    // Widths and timing
    localparam int KEY_PINS = 16;
    localparam int ITV_BITS = 8;
    localparam int FAST_TAP = 1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_CYCLES_LOG2 = 19;
    localparam logic [ITV_BITS-1:0] ITV_MAX = 8'hFF;

    // Wake and interrupt sources, one bit each
    typedef struct packed {
        logic itv;
        logic wdt;
        logic ext_b;
        logic ext_a;
        logic key;
    } irq_src_t;

    // Power modes
    typedef enum logic [2:0] {
        ST_POR,
        ST_RST,
        ST_RUN,
        ST_SLEEP,
        ST_STOP,
        ST_STAB,
        ST_LOWV
    } pwr_mode_t;

endpackage

// file: standby_reset_lowvolt_ctrl.sv
// Standby, power-on and pin reset sequencing and low-voltage control with APB registers
// Function
// - Sleep register write one enters SLEEP
// - Peripheral taps gateable in SLEEP, tap10 never
// - Peripheral clock enable zero halts peripheral clocks
// - Interval timer counts in SLEEP only on tap10
// - STOP halts oscillator, all state kept
// - Reset, key, external irqs release either standby
// - Interval and watchdog overflow release SLEEP only
// - STOP release waits stabilization, then sets clock enable
// - Only enabled sources wake; I=0 resumes in line
// - I=1 wake branches to service routine
// - External irq wakes on rising edge
// - Selected key pin at wake level releases
// - Pending enabled interrupt blocks standby entry
// - Power-on reset lasts 2^19 clock cycles
// - POR clears prescaler, timer, detector; tap10 forced
// - Low supply enters low-voltage mode
// - Low-voltage mode left only through reset
// - Battery level register read-only, two bits
// - Key select registers enable pins, reset zero
// - Write-only wake level register, reset zero
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module standby_reset_lowvolt_ctrl #(
    parameter int TAP_BIT = 10 // Prescaler tap that clocks the timer during reset
) (
    input wire logic pclk, // System clock, 100 MHz
    input wire logic presetn, // Asynchronous reset, power-on
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic reset_pin_n, // External reset pin, active low
    input wire logic por_pulse, // Power-on detect pulse
    input wire logic stop_req, // CPU executes STOP, one-cycle pulse
    input wire standby_pkg::irq_src_t irq_en, // Individual interrupt enables
    input wire logic global_irq_flag, // Global interrupt flag of status_word
    input wire logic irq_pending, // Some request flag and enable both set
    input wire logic [15:0] key_wake_input, // Key-scan pins
    input wire logic ext_irq_a, // External interrupt pin A
    input wire logic ext_irq_b, // External interrupt pin B
    input wire logic watchdog_ovf_flag, // Watchdog overflow pulse
    input wire logic lowvolt_det, // Supply below detection level
    input wire logic [1:0] battery_det, // Supply below indication levels
    output logic cpu_clk_en, // CPU clock running
    output logic osc_en, // Oscillator running
    output logic periph_clk_on, // Peripheral clocks running
    output logic [TAP_BIT:0] periph_taps, // Gated prescaler taps to peripherals
    output logic interval_ovf_flag, // Interval timer overflow pulse
    output logic sys_rst_n, // System reset to the core, active low
    output logic resume_inline, // Wake pulse, continue after standby
    output logic wake_vector, // Wake pulse, branch to service routine
    output standby_pkg::irq_src_t wake_src, // Source of the last wake
    output logic lowvolt_mode, // Ports input with pull-ups, irqs off
    output logic remout_low // Remote output forced low
);
    import standby_pkg::*;

    typedef struct packed {
        pwr_mode_t mode;
        logic rst_stab;
        logic [TAP_BIT:0] pres;
        logic [ITV_BITS-1:0] itv;
        logic ovf_det;
        logic ext_a_prev;
        logic ext_b_prev;
        logic periph_en;
        logic tap10_sel;
        logic tap_gate;
        logic [2:0] sts;
        logic [7:0] keysel0;
        logic [7:0] keysel1;
        logic [15:0] wake_lvl;
        logic lvd_en;
        logic [1:0] batt;
        irq_src_t last_src;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cpu_clk_en;
        logic osc_en;
        logic periph_on;
        logic [TAP_BIT:0] taps;
        logic itv_ovf;
        logic sys_rst_n;
        logic resume;
        logic vector;
        irq_src_t wake_src;
        logic lowv;
        logic remout_low;
    } state_t;

    localparam state_t ST_INIT = '{
        mode: ST_POR, rst_stab: 1'b0, pres: '0, itv: '0, ovf_det: 1'b0,
        ext_a_prev: 1'b0, ext_b_prev: 1'b0, periph_en: PCLK_EN_RST,
        tap10_sel: TAP10_SEL_RST, tap_gate: TAP_GATE_RST, sts: STS_RST,
        keysel0: KEYSEL_RST, keysel1: KEYSEL_RST, wake_lvl: WAKELVL_RST,
        lvd_en: LVD_EN_RST, batt: 2'h0, last_src: '0, pready: 1'b0,
        pslverr: 1'b0, prdata: 32'h0000_0000, cpu_clk_en: 1'b0, osc_en: 1'b1,
        periph_on: 1'b0, taps: '0, itv_ovf: 1'b0, sys_rst_n: 1'b0,
        resume: 1'b0, vector: 1'b0, wake_src: '0, lowv: 1'b0, remout_low: 1'b0
    };

    state_t q;
    state_t n;

    // Address decode, used only for the error answer
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == OFS_SLEEP) || (a == OFS_CLOCK) || (a == OFS_KEYSEL0) ||
                  (a == OFS_KEYSEL1) || (a == OFS_WAKELVL) || (a == OFS_LOWVOLT_CTRL_REG) ||
                  (a == OFS_BATT) || (a == OFS_STATUS);
    endfunction

    // Read multiplexer; write-only wake level reads zero
    function automatic logic [31:0] rd_mux(input state_t s, input logic [7:0] a);
        rd_mux = 32'h0000_0000;
        unique case (a)
            OFS_SLEEP: rd_mux[SLP_ENTER] = (s.mode == ST_SLEEP);
            OFS_CLOCK: begin
                rd_mux[CK_PCLK_EN] = s.periph_en;
                rd_mux[CK_TAP10_SEL] = s.tap10_sel;
                rd_mux[CK_TAP_GATE] = s.tap_gate;
                rd_mux[CK_STS_HI:CK_STS_LO] = s.sts;
            end
            OFS_KEYSEL0: rd_mux[7:0] = s.keysel0;
            OFS_KEYSEL1: rd_mux[7:0] = s.keysel1;
            OFS_LOWVOLT_CTRL_REG: rd_mux[LVD_EN] = s.lvd_en;
            OFS_BATT: rd_mux[1:0] = s.batt;
            OFS_STATUS: begin
                rd_mux[STAT_SRC_HI:0] = s.last_src;
                rd_mux[STAT_LOWV] = (s.mode == ST_LOWV);
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    endfunction

    logic running;
    logic tick10;
    logic tickf;
    logic itv_tick;
    logic itv_wrap;
    logic access;
    logic commit;
    logic sleep_wr;
    logic key_hit;
    irq_src_t src;
    irq_src_t src_sleep;
    irq_src_t src_stop;

    always_comb begin
        n = q;
        n.itv_ovf = 1'b0;
        n.resume = 1'b0;
        n.vector = 1'b0;
        n.batt = battery_det;
        n.ext_a_prev = ext_irq_a;
        n.ext_b_prev = ext_irq_b;

        // Prescaler runs whenever the oscillator does; STOP and low voltage freeze it
        running = (q.mode != ST_STOP) && (q.mode != ST_LOWV);
        tick10 = running && (&q.pres);
        tickf = running && (&q.pres[FAST_TAP:0]);
        if (running) begin
            n.pres = q.pres + {{TAP_BIT{1'b0}}, 1'b1};
        end

        // Timer clock: tap10 forced through reset and stabilization
        unique case (q.mode)
            ST_POR, ST_RST, ST_STAB: itv_tick = tick10;
            ST_RUN: itv_tick = q.tap10_sel ? tick10 : tickf;
            ST_SLEEP: itv_tick = q.tap10_sel && tick10;
            default: itv_tick = 1'b0;
        endcase
        itv_wrap = itv_tick && (q.itv == ITV_MAX);
        if (itv_tick) begin
            n.itv = q.itv + 8'h01;
        end
        if (itv_wrap && ((q.mode == ST_RUN) || (q.mode == ST_SLEEP))) begin
            n.itv_ovf = 1'b1;
        end

        // Wake sources, each gated by its own enable
        key_hit = |({q.keysel1, q.keysel0} & ~(key_wake_input ^ q.wake_lvl));
        src.key = key_hit;
        src.ext_a = ext_irq_a && !q.ext_a_prev;
        src.ext_b = ext_irq_b && !q.ext_b_prev;
        src.itv = itv_wrap;
        src.wdt = watchdog_ovf_flag;
        src_sleep = src & irq_en;
        src_stop = src & irq_en & irq_src_t'{itv: 1'b0, wdt: 1'b0, ext_b: 1'b1,
                                   ext_a: 1'b1, key: 1'b1};

        // APB slave: one wait cycle, effects at the completing edge
        access = psel && penable;
        commit = access && q.pready;
        n.pready = access && !q.pready;
        n.pslverr = access && !q.pready && !addr_ok(paddr);
        if (access && !q.pready) begin
            n.prdata = rd_mux(q, paddr);
        end
        sleep_wr = 1'b0;
        if (commit && pwrite) begin
            unique case (paddr)
                OFS_SLEEP: sleep_wr = pwdata[SLP_ENTER];
                OFS_CLOCK: begin
                    n.periph_en = pwdata[CK_PCLK_EN];
                    n.tap10_sel = pwdata[CK_TAP10_SEL];
                    n.tap_gate = pwdata[CK_TAP_GATE];
                    n.sts = pwdata[CK_STS_HI:CK_STS_LO];
                end
                OFS_KEYSEL0: n.keysel0 = pwdata[7:0];
                OFS_KEYSEL1: n.keysel1 = pwdata[7:0];
                OFS_WAKELVL: n.wake_lvl = pwdata[15:0];
                OFS_LOWVOLT_CTRL_REG: n.lvd_en = pwdata[LVD_EN];
                default: sleep_wr = 1'b0;
            endcase
        end

        // Power mode sequencing
        unique case (q.mode)
            ST_POR: begin
                if (itv_wrap) begin
                    n.ovf_det = 1'b1;
                    n.mode = ST_RUN;
                end
            end
            ST_RST: begin
                n.mode = ST_STAB;
                n.rst_stab = 1'b1;
                n.pres = '0;
                n.itv = '0;
            end
            ST_RUN: begin
                // Entry refused while an enabled request is pending
                if (sleep_wr && !irq_pending) begin
                    n.mode = ST_SLEEP;
                end else if (stop_req && !irq_pending) begin
                    n.mode = ST_STOP;
                end
            end
            ST_SLEEP: begin
                if (|src_sleep) begin
                    n.mode = ST_RUN;
                    n.last_src = src_sleep;
                    n.wake_src = src_sleep;
                    n.vector = global_irq_flag;
                    n.resume = !global_irq_flag;
                end
            end
            ST_STOP: begin
                // Oscillator restarts; counters cleared to time the stabilization
                if (|src_stop) begin
                    n.mode = ST_STAB;
                    n.rst_stab = 1'b0;
                    n.last_src = src_stop;
                    n.pres = '0;
                    n.itv = '0;
                end
            end
            ST_STAB: begin
                if (q.itv[q.sts]) begin
                    n.mode = ST_RUN;
                    n.periph_en = 1'b1;
                    n.rst_stab = 1'b0;
                    if (!q.rst_stab) begin
                        n.wake_src = q.last_src;
                        n.vector = global_irq_flag;
                        n.resume = !global_irq_flag;
                    end
                end
            end
            ST_LOWV: n.mode = ST_LOWV;
        endcase

        // Supply drop overrides every mode except reset
        if (lowvolt_det && q.lvd_en && (q.mode != ST_POR) && (q.mode != ST_RST)) begin
            n.mode = ST_LOWV;
        end

        // Pin reset: registers to reset values, RAM untouched
        if (!reset_pin_n) begin
            n = ST_INIT;
            n.mode = ST_RST;
            n.batt = battery_det;
            n.pready = access && !q.pready;
            n.pslverr = access && !q.pready && !addr_ok(paddr);
            n.prdata = q.prdata;
        end

        // Power-on detect restarts the count
        if (por_pulse) begin
            n = ST_INIT;
        end

        // Registered outputs follow the next mode
        n.osc_en = (n.mode != ST_STOP) && (n.mode != ST_LOWV);
        n.cpu_clk_en = (n.mode == ST_RUN);
        n.periph_on = n.osc_en && n.periph_en;
        n.taps = '0;
        if (n.osc_en) begin
            n.taps[TAP_BIT] = n.pres[TAP_BIT];
            if (n.periph_en && !((n.mode == ST_SLEEP) && n.tap_gate)) begin
                n.taps[TAP_BIT-1:0] = n.pres[TAP_BIT-1:0];
            end
        end
        n.sys_rst_n = (n.mode != ST_POR) && (n.mode != ST_RST) &&
                      !((n.mode == ST_STAB) && n.rst_stab);
        n.lowv = (n.mode == ST_LOWV);
        n.remout_low = (n.mode == ST_LOWV);
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= ST_INIT;
        end else begin
            q <= n;
        end
    end

    // Outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign cpu_clk_en = q.cpu_clk_en;
    assign osc_en = q.osc_en;
    assign periph_clk_on = q.periph_on;
    assign periph_taps = q.taps;
    assign interval_ovf_flag = q.itv_ovf;
    assign sys_rst_n = q.sys_rst_n;
    assign resume_inline = q.resume;
    assign wake_vector = q.vector;
    assign wake_src = q.wake_src;
    assign lowvolt_mode = q.lowv;
    assign remout_low = q.remout_low;

endmodule

// file: standby_checker_assertions.sv
// Concurrent checks on the standby controller's ports
`timescale 1ns/1ps
module standby_checker
    import standby_pkg::*;
#(
    parameter int TAP_BIT = 10 // Prescaler tap index
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic pready, // APB ready
    input wire logic stop_req, // STOP pulse
    input wire logic irq_pending, // Pending enabled request
    input wire logic global_irq_flag, // Global interrupt flag
    input wire logic reset_pin_n, // Pin reset, active low
    input wire logic por_pulse, // Power-on detect
    input wire logic lowvolt_det, // Low supply
    input wire logic cpu_clk_en, // CPU clock running
    input wire logic osc_en, // Oscillator running
    input wire logic periph_clk_on, // Peripheral clocks running
    input wire logic [TAP_BIT:0] periph_taps, // Gated taps
    input wire logic interval_ovf_flag, // Timer overflow pulse
    input wire logic resume_inline, // Wake, in line
    input wire logic wake_vector, // Wake, to service routine
    input wire logic lowvolt_mode, // Low-voltage mode
    input wire logic remout_low // Remote output low
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // No reset source or low supply: requests honoured
    wire calm = reset_pin_n && !por_pulse && !lowvolt_det;
    a_sleep_write_stops: assert property (psel && penable && pready && pwrite
        && paddr == OFS_SLEEP && pwdata[0] && cpu_clk_en && !irq_pending && calm
        |=> !cpu_clk_en) else $error("sleep write left cpu clock on");
    a_stop_halts_osc: assert property (stop_req && cpu_clk_en && !irq_pending && calm
        |=> !osc_en) else $error("stop did not halt oscillator");
    a_pending_blocks_stop: assert property (stop_req && cpu_clk_en && irq_pending && calm
        |=> osc_en) else $error("stop entered with pending request");
    a_no_timer_stopped: assert property (!osc_en && !$past(osc_en)
        |-> !interval_ovf_flag) else $error("timer overflow with oscillator off");
    a_lowvolt_state: assert property (lowvolt_mode
        |-> !osc_en && remout_low && !cpu_clk_en) else $error("low-voltage outputs wrong");
    a_lowvolt_sticks: assert property (lowvolt_mode && reset_pin_n && !por_pulse
        |=> lowvolt_mode) else $error("low-voltage mode left without reset");
    a_inline_flag_zero: assert property (resume_inline
        |-> !global_irq_flag && !wake_vector) else $error("inline resume with flag set");
    a_vector_flag_one: assert property (wake_vector
        |-> global_irq_flag && !resume_inline) else $error("vectored wake with flag clear");
    a_taps_gated_off: assert property (!periph_clk_on && osc_en
        |-> periph_taps[TAP_BIT-1:0] == '0) else $error("taps run with clocks off");
    // Main scenarios reached
    c_vector: cover property (wake_vector);
    c_inline: cover property (resume_inline);
    c_lowvolt: cover property (lowvolt_mode);
    c_stop: cover property (!osc_en && !lowvolt_mode);
endmodule

// file: cpu_model.sv
// CPU core model issuing STOP and presenting pending requests
`timescale 1ns/1ps
module cpu_model (
    input wire logic pclk, // Clock
    input wire logic go_stop, // Command: execute STOP
    input wire logic pend, // Command: request and enable set
    output logic stop_req, // STOP pulse to the block
    output logic irq_pending // Pending enabled request
);
    logic nop_q = 1'b0; // NOP slot after a standby instruction
    // One-cycle STOP, then a NOP slot so no request follows at once
    always @(posedge pclk) begin
        stop_req <= go_stop && !stop_req && !nop_q;
        nop_q <= stop_req;
    end
    assign irq_pending = pend;
endmodule

// file: tb_top.sv
// Self-checking bench for the standby, reset and low-voltage controller
`timescale 1ns/1ps
module tb_top;
    import standby_pkg::*;
    localparam int TAP_BIT = 3; // Short prescaler keeps reset counts small
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic pready, pslverr, stop_req, irq_pending, cpu_clk_en, osc_en, periph_clk_on, itv, erv;
    logic sys_rst_n, resume_inline, wake_vector, lowvolt_mode, remout_low;
    logic reset_pin_n = 1'b1, por_pulse = 1'b0, go_stop = 1'b0, pend = 1'b0, gflag = 1'b0;
    logic ext_a = 1'b0, ext_b = 1'b0, wdt = 1'b0, lowv = 1'b0;
    logic [1:0] batt = 2'h2;
    logic [15:0] keys = 16'hFFFF;
    logic [TAP_BIT:0] taps;
    irq_src_t irq_en = 5'h00, wake_src;
    int n_errors = 0, checks_done = 0;
    always #5 pclk = ~pclk;
    cpu_model i_cpu (.pclk(pclk), .go_stop(go_stop), .pend(pend), .stop_req(stop_req),
        .irq_pending(irq_pending));
    standby_reset_lowvolt_ctrl #(.TAP_BIT(TAP_BIT)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n),
        .por_pulse(por_pulse), .stop_req(stop_req), .irq_en(irq_en),
        .global_irq_flag(gflag), .irq_pending(irq_pending), .key_wake_input(keys),
        .ext_irq_a(ext_a), .ext_irq_b(ext_b), .watchdog_ovf_flag(wdt), .lowvolt_det(lowv),
        .battery_det(batt), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
        .periph_clk_on(periph_clk_on), .periph_taps(taps), .interval_ovf_flag(itv),
        .sys_rst_n(sys_rst_n), .resume_inline(resume_inline), .wake_vector(wake_vector),
        .wake_src(wake_src), .lowvolt_mode(lowvolt_mode), .remout_low(remout_low));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    // One APB transfer, held until pready at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic er);
        int k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_errors++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdv, erv);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        apb(1'b0, a, 32'h0, v, erv);
    endtask
    task automatic enter_sleep();
        wr(OFS_SLEEP, 32'h1);
        cyc(2);
        check(cpu_clk_en, 32'h0, "sleep not entered");
    endtask
    // Raise one wake source: 0 key, 1 pin A, 2 pin B, 3 watchdog
    task automatic fire(input int i);
        @(posedge pclk);
        case (i)
            0: keys[0] <= 1'b0;
            1: ext_a <= 1'b1;
            2: ext_b <= 1'b1;
            default: wdt <= 1'b1;
        endcase
    endtask
    task automatic quiet();
        @(posedge pclk);
        keys <= 16'hFFFF;
        ext_a <= 1'b0;
        ext_b <= 1'b0;
    endtask
    // Watchdog pulse drops at the first edge
    task automatic wait_wake(input int bound, output logic hit, output int n);
        hit = 1'b0;
        for (n = 0; n < bound && !hit; n++) begin
            @(posedge pclk);
            wdt <= 1'b0;
            #1;
            hit = (resume_inline === 1'b1) || (wake_vector === 1'b1);
        end
    endtask
    task automatic t_por();
        int n = 0;
        while (sys_rst_n !== 1'b1 && n < 5000) begin
            cyc(1);
            n++;
        end
        check(n, 1 << (TAP_BIT + ITV_BITS + 1), "power-on reset length");
        $display("t_por done");
    endtask
    task automatic t_regs();
        logic [31:0] v;
        rd(OFS_CLOCK, v);
        check(v, {26'h0, STS_RST, TAP_GATE_RST, TAP10_SEL_RST, PCLK_EN_RST}, "clock reset");
        rd(OFS_KEYSEL0, v);
        check(v, 32'h0, "key select 0 reset");
        rd(OFS_KEYSEL1, v);
        check(v, 32'h0, "key select 1 reset");
        wr(OFS_WAKELVL, 32'hFFFE);
        rd(OFS_WAKELVL, v);
        check(v, 32'h0, "wake level readable");
        wr(OFS_BATT, 32'h0);
        rd(OFS_BATT, v);
        check(v, 32'h2, "battery level");
        apb(1'b0, 8'h20, 32'h0, v, erv);
        check(erv, 32'h1, "unmapped address accepted");
        $display("t_regs done");
    endtask
    task automatic t_sleep();
        logic hit;
        int n;
        wr(OFS_KEYSEL0, 32'h1);
        enter_sleep();
        fire(1);
        wait_wake(30, hit, n);
        check(hit, 32'h0, "disabled source woke");
        for (int i = 0; i < 4; i++) begin
            quiet();
            irq_en <= 5'(1 << i);
            gflag <= i[0];
            if (i > 0) enter_sleep();
            fire(i);
            wait_wake(50, hit, n);
            check(hit, 32'h1, "no wake from source");
            check(wake_vector, 32'(i[0]), "vectored wake");
            check(resume_inline, 32'(!i[0]), "inline wake");
            check(wake_src, 32'(1 << i), "wake source");
        end
        quiet();
        $display("t_sleep done");
    endtask
    task automatic t_timer();
        logic hit;
        int n;
        logic moved = 1'b0;
        logic [TAP_BIT:0] t0;
        irq_en <= 5'h00;
        gflag <= 1'b0;
        wr(OFS_CLOCK, 32'h3F);
        enter_sleep();
        t0 = taps;
        repeat (20) begin
            cyc(1);
            moved = moved | (taps[TAP_BIT] !== t0[TAP_BIT]);
        end
        check(taps[TAP_BIT-1:0], 32'h0, "gated taps run");
        check(moved, 32'h1, "tap10 stopped");
        irq_en <= 5'h10;
        wait_wake(4200, hit, n);
        check(hit, 32'h1, "timer did not wake");
        check(itv, 32'h1, "no overflow pulse");
        irq_en <= 5'h00;
        wr(OFS_CLOCK, 32'h39);
        enter_sleep();
        irq_en <= 5'h10;
        wait_wake(4200, hit, n);
        check(hit, 32'h0, "fast tap timer woke");
        irq_en <= 5'h12;
        fire(1);
        wait_wake(50, hit, n);
        check(hit, 32'h1, "pin wake");
        quiet();
        $display("t_timer done");
    endtask
    task automatic t_stop();
        logic hit;
        int n;
        irq_en <= 5'h0C;
        gflag <= 1'b1;
        wr(OFS_CLOCK, 32'h3A);
        cyc(2);
        check(periph_clk_on, 32'h0, "peripheral clock on");
        check(taps[TAP_BIT-1:0], 32'h0, "taps run");
        for (int p = 1; p >= 0; p--) begin
            @(posedge pclk);
            pend <= p[0];
            go_stop <= 1'b1;
            @(posedge pclk);
            go_stop <= 1'b0;
            cyc(3);
            check(osc_en, 32'(p[0]), "stop entry");
        end
        fire(3);
        wait_wake(50, hit, n);
        check(hit, 32'h0, "watchdog woke stop");
        fire(2);
        wait_wake(3000, hit, n);
        check(32'(n >= 2040 && n <= 2100), 32'h1, "stabilization time");
        check(wake_vector, 32'h1, "vectored stop wake");
        cyc(1);
        check(periph_clk_on, 32'h1, "clock enable not set");
        quiet();
        $display("t_stop done");
    endtask
    task automatic t_lowv();
        logic hit;
        logic [31:0] v;
        int n;
        @(posedge pclk);
        lowv <= 1'b1;
        cyc(3);
        check({lowvolt_mode, remout_low, osc_en}, 32'h6, "low-voltage entry");
        @(posedge pclk);
        lowv <= 1'b0;
        irq_en <= 5'h02;
        fire(1);
        wait_wake(30, hit, n);
        check({hit, lowvolt_mode}, 32'h1, "low-voltage left");
        quiet();
        reset_pin_n <= 1'b0;
        cyc(2);
        @(posedge pclk);
        reset_pin_n <= 1'b1;
        cyc(2);
        check(lowvolt_mode, 32'h0, "reset kept low-voltage");
        n = 0;
        while (cpu_clk_en !== 1'b1 && n < 3000) begin
            cyc(1);
            n++;
        end
        check(cpu_clk_en, 32'h1, "no run after reset");
        rd(OFS_KEYSEL0, v);
        check(v, 32'h0, "key select after reset");
        $display("t_lowv done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_por();
        t_regs();
        t_sleep();
        t_timer();
        t_stop();
        t_lowv();
        complete_run();
    end
endmodule
bind standby_reset_lowvolt_ctrl standby_checker #(.TAP_BIT(TAP_BIT)) i_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .stop_req(stop_req), .irq_pending(irq_pending),
    .global_irq_flag(global_irq_flag), .reset_pin_n(reset_pin_n), .por_pulse(por_pulse),
    .lowvolt_det(lowvolt_det), .cpu_clk_en(cpu_clk_en), .osc_en(osc_en),
    .periph_clk_on(periph_clk_on), .periph_taps(periph_taps),
    .interval_ovf_flag(interval_ovf_flag), .resume_inline(resume_inline),
    .wake_vector(wake_vector), .lowvolt_mode(lowvolt_mode), .remout_low(remout_low));
